/* core/sapc_cfg.svh */
`ifndef SAPC_CFG_SVH
`define SAPC_CFG_SVH
`define SAPC_CLK_MHZ        40
`define SAPC_PERIOD_NS      25
// Times are in ns.
`define SAPC_T_ACQ_NS       53
`define SAPC_T_CS_W_NS      20
`define SAPC_T_BUSY_UP_NS   40
`define SAPC_T_BUSY_DN_NS   20
`define SAPC_T_RD_NS        25
`define SAPC_T_QUIET_NS     25
`define SAPC_T_B2B_NS       10
`define SAPC_T_CONV_NS      280
`define SAPC_T_RST_MIN_NS   45
`define SAPC_T_RST_MAX_NS   6140
`define SAPC_T_PD_NS        7200
`define SAPC_T_PU_NS        25
// Least times round up, longest times round down, never below one cycle.
`define SAPC_CYC_UP(t)  (((t) + `SAPC_PERIOD_NS - 1) / `SAPC_PERIOD_NS)
`define SAPC_CYC_DN(t)  ((((t) / `SAPC_PERIOD_NS) < 1) ? 1 : ((t) / `SAPC_PERIOD_NS))
`define SAPC_N_ACQ      (`SAPC_CYC_UP(`SAPC_T_ACQ_NS) + 1)
`define SAPC_N_CS       `SAPC_CYC_UP(`SAPC_T_CS_W_NS)
`define SAPC_N_BUSY_TO  (`SAPC_CYC_UP(`SAPC_T_BUSY_UP_NS + `SAPC_T_CONV_NS) + 4)
`define SAPC_N_RD       (`SAPC_CYC_UP(`SAPC_T_RD_NS) + 1)
`define SAPC_N_QUIET    `SAPC_CYC_UP(`SAPC_T_QUIET_NS)
`define SAPC_N_RST      (`SAPC_CYC_UP(`SAPC_T_RST_MIN_NS) + 1)
`define SAPC_N_RST_MAX  `SAPC_CYC_DN(`SAPC_T_RST_MAX_NS)
`define SAPC_N_PD       (`SAPC_CYC_UP(`SAPC_T_PD_NS) + 1)
`define SAPC_N_PU       (`SAPC_CYC_UP(`SAPC_T_PU_NS) + 1)
`define SAPC_RES_W      12
`define SAPC_BYTE_W     8
`define SAPC_FIFO_DEPTH 4
`endif

/* core/sapc_pkg.sv */
package sapc_pkg;
  typedef enum logic [3:0] {
    SAPC_IDLE  = 4'h0,
    SAPC_ACQ   = 4'h1,
    SAPC_QUIET = 4'h3,
    SAPC_CONV  = 4'h2,
    SAPC_BUSY  = 4'h6,
    SAPC_RDCS  = 4'h7,
    SAPC_RDEND = 4'h5,
    SAPC_RDHI  = 4'hE,
    SAPC_RDLO  = 4'hF,
    SAPC_PDLOW = 4'h4,
    SAPC_PDUP  = 4'hC
  } sapc_state_t;
endpackage

/* core/sapc_fifo.sv */
`timescale 1ns/1ps
module sapc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_idx];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sapc_fifo

/* core/sapc_host.sv */
`timescale 1ns/1ps
`include "sapc_cfg.svh"
module sapc_host
  import sapc_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rstn_i,
  input  wire logic                    start_i,
  input  wire logic                    abort_i,
  input  wire logic                    byte_mode_i,
  input  wire logic                    dev_reset_i,
  input  wire logic                    dev_powerdown_i,
  output logic                         ready_o,
  output logic                         result_valid_o,
  input  wire logic                    result_ready_i,
  output logic [`SAPC_RES_W-1:0]       result_o,
  output logic                         timeout_o,
  output logic                         convert_strobe_o,
  output logic                         cs_n_o,
  output logic                         rd_n_o,
  output logic                         byte_sel_o,
  output logic                         powerdown_reset_n_o,
  input  wire logic                    busy_i,
  input  wire logic [`SAPC_RES_W-1:0]  data_i
);
  ////////////////////////////////////////////////////////////////////////////
  sapc_state_t               state;
  logic [8:0]                cnt;
  logic [2:0]                busy_sync;
  logic                      busy_s;
  logic [`SAPC_RES_W-1:0]    word;
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  logic                      pd_req;
  logic                      abort_seen;
  logic                      got_word;

  // Busy is asynchronous to us; accept a change once the last two stages agree.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      busy_sync <= 3'h0;
      busy_s    <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], busy_i};
      if (busy_sync[1] == busy_sync[2]) begin
        busy_s <= busy_sync[2];
      end
    end
  end

  // A push still in flight counts as taken room, or a full FIFO would accept one more start.
  assign ready_o = (state == SAPC_IDLE) && fifo_in_ready && !fifo_in_valid;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state               <= SAPC_IDLE;
      cnt                 <= 9'h000;
      convert_strobe_o    <= 1'b1;
      cs_n_o              <= 1'b1;
      rd_n_o              <= 1'b1;
      byte_sel_o          <= 1'b0;
      powerdown_reset_n_o <= 1'b1;
      timeout_o           <= 1'b0;
      pd_req              <= 1'b0;
      word                <= 12'h000;
      fifo_in_valid       <= 1'b0;
      abort_seen          <= 1'b0;
      got_word            <= 1'b0;
    end else begin
      timeout_o     <= 1'b0;
      fifo_in_valid <= 1'b0;
      unique case (state)
        SAPC_IDLE: begin
          cnt        <= 9'h000;
          abort_seen <= 1'b0;
          got_word   <= 1'b0;
          if (dev_reset_i || dev_powerdown_i) begin
            pd_req              <= dev_powerdown_i;
            powerdown_reset_n_o <= 1'b0;
            state               <= SAPC_PDLOW;
          end else if (start_i && ready_o) begin
            cs_n_o <= 1'b0; // Strobe is high, so this opens acquisition
            state  <= SAPC_ACQ;
          end
        end
        SAPC_ACQ: begin
          cnt <= cnt + 9'h001;
          // Hold chip select and acquire before the quiet period ends
          if (cnt >= 9'(`SAPC_N_ACQ) && cnt >= 9'(`SAPC_N_CS)) begin
            cnt   <= 9'h000;
            state <= SAPC_QUIET;
          end
        end
        SAPC_QUIET: begin
          cnt <= cnt + 9'h001;
          // Bus stays released during the quiet window
          if (cnt >= 9'(`SAPC_N_QUIET)) begin
            convert_strobe_o <= 1'b0; // Falling strobe starts conversion
            cnt              <= 9'h000;
            state            <= SAPC_CONV;
          end
        end
        SAPC_CONV: begin
          cnt <= cnt + 9'h001;
          if (busy_s) begin
            convert_strobe_o <= 1'b1;
            cnt              <= 9'h000;
            state            <= SAPC_BUSY;
          end else if (cnt >= 9'(`SAPC_N_BUSY_TO)) begin
            timeout_o <= 1'b1;
            cnt       <= 9'h000;
            state     <= SAPC_RDEND;
          end
        end
        SAPC_BUSY: begin
          cnt <= cnt + 9'h001;
          if (abort_seen) begin
            cs_n_o <= 1'b0; // Falls with strobe and busy high
            cnt    <= 9'h000;
            state  <= SAPC_RDEND;
          end else if (abort_i && busy_s) begin
            // Only a falling chip select aborts, so it is raised for one cycle first.
            cs_n_o     <= 1'b1;
            abort_seen <= 1'b1;
          end else if (!busy_s) begin
            rd_n_o <= 1'b0; // Read only after busy has fallen
            cnt    <= 9'h000;
            state  <= byte_mode_i ? SAPC_RDHI : SAPC_RDCS;
          end else if (cnt >= 9'(`SAPC_N_BUSY_TO)) begin
            timeout_o <= 1'b1;
            cnt       <= 9'h000;
            state     <= SAPC_RDEND;
          end
        end
        SAPC_RDCS: begin
          cnt <= cnt + 9'h001;
          if (cnt >= 9'(`SAPC_N_RD)) begin
            word   <= data_i; // Sampled after the read access time
            got_word <= 1'b1;
            rd_n_o <= 1'b1;
            cnt    <= 9'h000;
            state  <= SAPC_RDEND;
          end
        end
        SAPC_RDHI: begin
          cnt <= cnt + 9'h001;
          if (cnt >= 9'(`SAPC_N_RD)) begin
            word[11:4] <= data_i[11:4];
            byte_sel_o <= 1'b1;
            cnt        <= 9'h000;
            state      <= SAPC_RDLO;
          end
        end
        SAPC_RDLO: begin
          cnt <= cnt + 9'h001;
          if (cnt >= 9'(`SAPC_N_RD)) begin
            word[3:0]  <= data_i[11:8]; // Low bits appear on the top lane
            got_word   <= 1'b1;
            byte_sel_o <= 1'b0;
            rd_n_o     <= 1'b1;
            cnt        <= 9'h000;
            state      <= SAPC_RDEND;
          end
        end
        SAPC_RDEND: begin
          cnt <= cnt + 9'h001;
          // Let the bus float before chip select rises or a new start
          if (cnt >= 9'(`SAPC_N_RD)) begin
            cs_n_o           <= 1'b1;
            convert_strobe_o <= 1'b1;
            fifo_in_valid    <= got_word; // Abort and timeout leave no result.
            cnt              <= 9'h000;
            state            <= SAPC_IDLE;
          end
        end
        SAPC_PDLOW: begin
          cnt <= cnt + 9'h001;
          // Pulse length picks reset or power-down
          if (!pd_req && cnt >= 9'(`SAPC_N_RST)) begin
            powerdown_reset_n_o <= 1'b1;
            cnt                 <= 9'h000;
            state               <= SAPC_PDUP;
          end else if (pd_req && cnt >= 9'(`SAPC_N_PD)) begin
            // Saturate so a long hold can never wrap back to a short count.
            cnt <= 9'(`SAPC_N_PD);
            if (!dev_powerdown_i) begin
              powerdown_reset_n_o <= 1'b1;
              cnt                 <= 9'h000;
              state               <= SAPC_PDUP;
            end
          end
        end
        SAPC_PDUP: begin
          cnt <= cnt + 9'h001;
          if (cnt >= 9'(`SAPC_N_PU)) begin
            pd_req <= 1'b0;
            state  <= SAPC_IDLE;
          end
        end
        default: begin
          state <= SAPC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The FIFO lets the consumer lag the converter by four results before starts stall.
  sapc_fifo #(
    .WIDTH (`SAPC_RES_W),
    .DEPTH (`SAPC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (word),
    .out_valid_o (result_valid_o),
    .out_ready_i (result_ready_i),
    .out_data_o  (result_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  AST_CS_HELD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(cs_n_o) |-> !cs_n_o [*2])
    else $error("Chip select pulse shorter than required.");
  AST_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(convert_strobe_o) |-> $past(rd_n_o) && rd_n_o && !cs_n_o)
    else $error("Read active near conversion start.");
  AST_START_ACQ: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(cs_n_o) && !abort_seen |-> convert_strobe_o && state == SAPC_ACQ)
    else $error("Chip select fell without acquisition.");
  AST_ABORT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(cs_n_o) && abort_seen |-> convert_strobe_o && busy_s && state == SAPC_RDEND)
    else $error("Abort without strobe and busy high.");
  AST_RST_LEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(powerdown_reset_n_o) && !pd_req |-> $past(!powerdown_reset_n_o, 2))
    else $error("Reset pulse too short.");
  AST_RST_MAX: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(powerdown_reset_n_o) && !pd_req |-> ##[1:8] powerdown_reset_n_o)
    else $error("Reset pulse too long.");
  AST_PD_LEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(powerdown_reset_n_o) && pd_req |-> $past(cnt) >= 9'(`SAPC_N_PD))
    else $error("Power-down hold too short.");
  AST_READ_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !rd_n_o |-> !cs_n_o)
    else $error("Read strobe without chip select.");
  AST_BYTE_RD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(byte_sel_o) |-> !rd_n_o [*3])
    else $error("Byte select changed outside a read.");
endmodule // sapc_host

/* testbench/sapc_adc_model.sv */
`timescale 1ns/1ps
module sapc_adc_model (
  input  wire logic        convert_strobe_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        byte_sel_i,
  input  wire logic        powerdown_reset_n_i,
  input  wire logic        slow_i,
  input  wire logic        mute_i,
  input  wire logic [11:0] level_i,
  output logic             busy_o,
  output logic [11:0]      data_o,
  output logic [7:0]       viol_o
);
  logic [11:0] result, last, latch;
  logic        acq, awake, pd_seen;
  int          gen;
  realtime     t_cs, t_bus, t_pd;
  wire         drive = !cs_n_i && !rd_n_i;
  wire  [11:0] cur   = byte_sel_i ? {result[3:0], 8'h00} : result;
  initial begin
    {busy_o, acq, awake, pd_seen} = 4'h2;
    {result, last, gen, viol_o} = '0;
    t_cs = 0.0;
    t_bus = 0.0;
    t_pd = 0.0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // A released bus shows the inverse of its last value, so a stale sample cannot pass.
  always @(drive) t_bus = $realtime;
  always @* if (drive) last = cur;
  assign #5 data_o = drive ? cur : ~last;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge convert_strobe_i) if (!cs_n_i) acq = 1'b1;
  always @(posedge cs_n_i) if (t_cs > 0 && $realtime - t_cs < 20) viol_o++;
  always @(negedge cs_n_i) begin
    t_cs = $realtime;
    if (convert_strobe_i) begin
      acq = 1'b1;
      if (busy_o) begin
        gen++;
        busy_o <= #10 1'b0;
      end
    end
  end
  always @(negedge convert_strobe_i or negedge cs_n_i)
    if (!convert_strobe_i && !cs_n_i && acq && awake && !busy_o && !mute_i) begin
      if ($realtime - t_bus < 25) viol_o++;
      acq = 1'b0;
      latch = level_i;
      gen++;
      fork
        begin
          automatic int my = gen;
          #(slow_i ? 35 : 10);
          if (my == gen) busy_o = 1'b1;
          #(slow_i ? 280 : 120);
          if (my == gen) begin
            result = latch;
            #5 busy_o = 1'b0;
          end
        end
      join_none
    end
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge powerdown_reset_n_i) if (powerdown_reset_n_i === 1'b0) begin
    {pd_seen, awake, busy_o, result} = {2'h2, 1'b0, 12'h000};
    gen++;
    t_pd = $realtime;
  end
  always @(posedge powerdown_reset_n_i) if (pd_seen) begin
    pd_seen = 1'b0;
    // Widths between the reset and power-down windows leave the part undefined.
    if ($realtime - t_pd < 45 || ($realtime - t_pd > 6140 && $realtime - t_pd < 7200))
      viol_o++;
    awake <= #25 1'b1;
  end
endmodule // sapc_adc_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "sapc_cfg.svh"
module tb_top;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
  localparam int LIM = 400;
  logic                   clk_sys_i, rstn_i, start_i, abort_i, byte_mode_i, dev_reset_i;
  logic                   dev_powerdown_i, result_ready_i, ready_o, result_valid_o, timeout_o;
  logic                   convert_strobe_o, cs_n_o, rd_n_o, byte_sel_o, powerdown_reset_n_o;
  logic                   busy_i, slow, mute;
  logic [`SAPC_RES_W-1:0] result_o, data_i, level, exp_v;
  logic [7:0]             viol;
  int                     errors, comparisons, n, sink;
  logic [11:0]            q[$];
  sapc_host dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start_i), .abort_i(abort_i),
    .byte_mode_i(byte_mode_i), .dev_reset_i(dev_reset_i), .dev_powerdown_i(dev_powerdown_i),
    .ready_o(ready_o), .result_valid_o(result_valid_o), .result_ready_i(result_ready_i),
    .result_o(result_o), .timeout_o(timeout_o), .convert_strobe_o(convert_strobe_o),
    .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .byte_sel_o(byte_sel_o),
    .powerdown_reset_n_o(powerdown_reset_n_o), .busy_i(busy_i), .data_i(data_i));
  sapc_adc_model adc_u (.convert_strobe_i(convert_strobe_o), .cs_n_i(cs_n_o), .rd_n_i(rd_n_o),
    .byte_sel_i(byte_sel_o), .powerdown_reset_n_i(powerdown_reset_n_o), .slow_i(slow),
    .mute_i(mute), .level_i(level), .busy_o(busy_i), .data_o(data_i), .viol_o(viol));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sink: 0 always ready, 1 random stalls, 2 stalled.
  always @(posedge clk_sys_i) begin
    result_ready_i <= (sink == 2) ? 1'b0 : (sink == 1) ? 1'($urandom) : 1'b1;
  end
  always @(posedge clk_sys_i) begin
    if (rstn_i && result_valid_o === 1'b1 && result_ready_i === 1'b1) begin
      `CHK(q.size() != 0, 1'b1)
      if (q.size() != 0) begin
        exp_v = q.pop_front();
        `CHK(result_o, exp_v)
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail_now();
    errors++;
    report_and_stop();
  endtask
  // The new level and mode are applied only once the start is taken, so an earlier
  // conversion that has not latched its input yet keeps its own level.
  task automatic convert(input logic bm, input logic keep);
    int k;
    logic [11:0] lv;
    lv = 12'($urandom);
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    k = 0;
    do begin @(posedge clk_sys_i); k++; end while (ready_o !== 1'b1 && k < LIM);
    start_i     <= 1'b0;
    level       <= lv;
    byte_mode_i <= bm;
    if (k >= LIM) fail_now();
    if (keep) q.push_back(lv);
  endtask
  task automatic wait_ready();
    int k;
    repeat (2) @(posedge clk_sys_i);
    for (k = 0; k < LIM && ready_o !== 1'b1; k++) @(posedge clk_sys_i);
    if (k >= LIM) fail_now();
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < LIM && q.size() != 0; k++) @(posedge clk_sys_i);
    if (k >= LIM) fail_now();
    wait_ready();
  endtask
  task automatic pin_low_len(output int len);
    int k;
    for (k = 0; k < LIM && powerdown_reset_n_o !== 1'b0; k++) @(posedge clk_sys_i);
    if (k >= LIM) fail_now();
    for (len = 0; len < LIM && powerdown_reset_n_o === 1'b0; len++) @(posedge clk_sys_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0D3B));
    {rstn_i, start_i, abort_i, byte_mode_i, dev_reset_i, dev_powerdown_i} = 6'h00;
    {slow, mute, sink, level, errors, comparisons} = '0;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    sink = 1;
    for (int i = 0; i < 12; i++) convert(1'($urandom), 1'b1);
    drain();
    sink = 2;
    for (int i = 0; i < 4; i++) convert(i[0], 1'b1);
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    n = 0;
    repeat (60) begin @(posedge clk_sys_i); if (ready_o === 1'b1) n++; end
    start_i <= 1'b0;
    `CHK(n, 0)
    sink = 0;
    drain();
    // A slow conversion gives the abort time to land while busy stands.
    {slow, abort_i} <= 2'h3;
    convert(1'b0, 1'b0);
    wait_ready();
    {slow, abort_i} <= 2'h0;
    `CHK(result_valid_o, 1'b0)
    mute <= 1'b1;
    convert(1'b0, 1'b0);
    for (n = 0; n < 60 && timeout_o !== 1'b1; n++) @(posedge clk_sys_i);
    `CHK(timeout_o, 1'b1)
    mute <= 1'b0;
    wait_ready();
    dev_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    dev_reset_i <= 1'b0;
    pin_low_len(n);
    `CHK(n, `SAPC_N_RST + 1)
    `CHK(n * `SAPC_PERIOD_NS >= `SAPC_T_RST_MIN_NS, 1'b1)
    `CHK(n * `SAPC_PERIOD_NS <= `SAPC_T_RST_MAX_NS, 1'b1)
    wait_ready();
    dev_powerdown_i <= 1'b1;
    @(posedge clk_sys_i);
    dev_powerdown_i <= 1'b0;
    pin_low_len(n);
    `CHK(n >= 288, 1'b1)
    `CHK(n, `SAPC_N_PD + 1)
    convert(1'b1, 1'b1);
    drain();
    `CHK(viol, 8'h00)
    `CHK(q.size(), 0)
    report_and_stop();
  end
endmodule // tb_top
